/* pkg/adc_regs_pkg.sv */
package adc_regs_pkg;

    localparam int NUM_REGS = 14;
    localparam int ADDR_W = 5;
    localparam int INIT_W = 12;
    localparam int SAMPLE_W = 16;

    // register offsets
    localparam logic [4:0] POWER_CONTROL_A = 5'h00;
    localparam logic [4:0] PLL_AND_ROLE_CONTROL = 5'h01;
    localparam logic [4:0] INPUT_ROUTING_A = 5'h02;
    localparam logic [4:0] MIC_GAIN_A = 5'h03;
    localparam logic [4:0] SERIAL_FORMAT = 5'h04;
    localparam logic [4:0] RATE_AND_FILTER_SELECT = 5'h05;
    localparam logic [4:0] CLOCK_OUTPUT_CONFIG = 5'h06;
    localparam logic [4:0] VOLUME_MODE_A = 5'h07;
    localparam logic [4:0] LEFT_VOLUME_A = 5'h08;
    localparam logic [4:0] RIGHT_VOLUME_A = 5'h09;
    localparam logic [4:0] LEVEL_TIMER_A = 5'h0a;
    localparam logic [4:0] LEVEL_REFERENCE_A = 5'h0b;
    localparam logic [4:0] LEVEL_CONTROL_A = 5'h0c;
    localparam logic [4:0] MODE_CONTROL_ONE = 5'h0d;

    // reset values, indexed by offset
    localparam logic [NUM_REGS-1:0][7:0] RESET_VALUES = {
        8'ha0, 8'h00, 8'he1, 8'h00, 8'h91, 8'h91, 8'h01,
        8'h00, 8'h1f, 8'h23, 8'h01, 8'h00, 8'h24, 8'h00};
    // writable bits; the rest hold their fixed value
    localparam logic [NUM_REGS-1:0][7:0] WRITE_MASKS = {
        8'hf3, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h01,
        8'h87, 8'hff, 8'hdf, 8'h03, 8'h7f, 8'h3f, 8'h07};

    // field positions
    localparam int LEFT_A_POWER = 0;
    localparam int RIGHT_A_POWER = 1;
    localparam int COMMON_VOLTAGE_POWER = 2;
    localparam int PLL_POWER = 0;
    localparam int MASTER_SELECT = 1;
    localparam int PLL_REF_LSB = 2;
    localparam int LEFT_A_PIN_SELECT = 0;
    localparam int RIGHT_A_PIN_SELECT = 1;
    localparam int LEFT_A_DIFFERENTIAL = 2;
    localparam int RIGHT_A_DIFFERENTIAL = 3;
    localparam int MIC_SUPPLY_A_ENABLE = 4;
    localparam int LEFT_A_PIN5_SELECT = 5;
    localparam int RIGHT_A_PIN5_SELECT = 6;
    localparam int SERIAL_FORMAT_LSB = 0;
    localparam int BITCLOCK_POLARITY = 2;
    localparam int FRAMECLOCK_PHASE = 3;
    localparam int MIX_A_ENABLE = 4;
    localparam int SLOT_FORMAT_LSB = 6;
    localparam int RATE_SELECT_LSB = 0;
    localparam int BITCLOCK_RATE_LSB = 4;
    localparam int HIGHPASS_A_LSB = 6;
    localparam int CLOCK_OUT_RATE_LSB = 0;
    localparam int CLOCK_OUT_ENABLE = 2;
    localparam int INIT_CYCLE_A_SELECT = 7;
    localparam int VOLUME_LINK_A = 0;
    localparam int RECOVERY_WAIT_LO_LSB = 0;
    localparam int ZERO_CROSS_LSB = 2;
    localparam int RECOVERY_WAIT_HI = 4;
    localparam int FIRST_RECOVERY_LSB = 5;
    localparam int LIMITER_THRESHOLD_LSB = 0;
    localparam int RECOVERY_STEP_LSB = 2;
    localparam int LIMITER_STEP_LSB = 4;
    localparam int LIMITER_ZERO_CROSS_DISABLE = 6;
    localparam int LEVEL_CONTROL_ENABLE = 7;
    localparam int LEVEL_CONTROL_LINK_ALL = 0;
    localparam int LIMITER_FAST_MODE = 1;
    localparam int TEST_UNLOCK_LSB = 4;

    // initialization lengths in sample periods
    localparam logic [INIT_W-1:0] INIT_LONG = 12'd3088;
    localparam logic [INIT_W-1:0] INIT_SHORT = 12'd1552;
    localparam logic [1:0] HIGHPASS_SHORT_OK = 2'h3;

endpackage

/* verilog/adc_group_a_control_registers.sv */
module adc_group_a_control_registers (
    // clock and reset
    input wire logic mclk,

    input wire logic rst_n,

    // power-down pin, low restores defaults everywhere
    input wire logic power_down_pin_n,

    // register port from the serial control decoder
    input wire logic reg_write,

    input wire logic reg_read,

    input wire logic [adc_regs_pkg::ADDR_W-1:0] reg_addr,

    input wire logic [7:0] reg_wdata,

    output logic [7:0] reg_rdata,

    output logic reg_rvalid,

    // sample timing and converter data
    input wire logic sample_tick,

    input wire logic [adc_regs_pkg::SAMPLE_W-1:0] adc_left,

    input wire logic [adc_regs_pkg::SAMPLE_W-1:0] adc_right,

    output logic [adc_regs_pkg::SAMPLE_W-1:0] out_left,

    output logic [adc_regs_pkg::SAMPLE_W-1:0] out_right,

    output logic out_valid,

    // analog power and routing controls
    output logic left_a_power,

    output logic right_a_power,

    output logic common_voltage_power,

    output logic left_a_ready,

    output logic right_a_ready,

    output logic mic_supply_a_enable,

    output logic [1:0] left_a_input,

    output logic [1:0] right_a_input,

    output logic left_a_differential,

    output logic right_a_differential,

    output logic [1:0] mic_gain_a,

    // clocking and serial format
    output logic pll_power,

    output logic master_mode,

    output logic [3:0] pll_reference_select,

    output logic [3:0] rate_select,

    output logic [1:0] bitclock_rate_select,

    output logic [1:0] serial_format_select,

    output logic [1:0] slot_format_select,

    output logic bitclock_polarity,

    output logic frameclock_phase,

    output logic [1:0] clock_out_rate_select,

    input wire logic clock_out_source,

    output logic clock_out,

    // volume and level control
    output logic [7:0] left_a_volume,

    output logic [7:0] right_a_volume,

    output logic [2:0] recovery_wait_a,

    output logic [1:0] zero_cross_timeout_a,

    output logic [1:0] first_recovery_speed_a,

    output logic [7:0] recovery_reference_a,

    output logic level_control_a_enable,

    output logic limiter_zero_cross_a_disable,

    output logic [1:0] limiter_step_a,

    output logic [1:0] recovery_step_a,

    output logic [1:0] limiter_threshold_a,

    output logic level_control_link_all,

    output logic limiter_fast_mode
);
    import adc_regs_pkg::*;

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;

        logic [1:0] power_prev;

        logic [1:0][INIT_W-1:0] init_count;

        logic [1:0] ready;

        logic [7:0] rdata;

        logic rvalid;

        logic clk_out;

        logic [SAMPLE_W-1:0] left;

        logic [SAMPLE_W-1:0] right;

        logic valid;
    } state_t;

    state_t cur;
    state_t next_cur;

    // init length depends on the high-pass setting; the short choice needs hpf 11
    function automatic logic [INIT_W-1:0] init_length(input logic [7:0] rate_reg,
                                                      input logic [7:0] clk_reg);
        if (rate_reg[HIGHPASS_A_LSB +: 2] == HIGHPASS_SHORT_OK
            && clk_reg[INIT_CYCLE_A_SELECT]) begin
            return INIT_SHORT;
        end

        return INIT_LONG;
    endfunction

    // input pin code: 0 pin1, 1 pin2, 2 pin5
    function automatic logic [1:0] pin_code(input logic pin2, input logic pin5);
        if (pin5) begin
            return 2'h2;
        end

        return {1'b0, pin2};
    endfunction

    //////////////////////////////////////////////////////////////////////////
    logic [SAMPLE_W:0] mix_sum;

    logic [1:0] power_now;

    // a channel is live only while both powered and initialised
    logic [1:0] live;

    always_comb begin
        next_cur = cur;

        mix_sum = {adc_left[SAMPLE_W-1], adc_left} + {adc_right[SAMPLE_W-1], adc_right};

        next_cur.rvalid = 1'b0;

        next_cur.valid = 1'b0;

        // only the writable bits change; fixed bits keep their constant
        if (reg_write && reg_addr < 5'(NUM_REGS)) begin
            next_cur.regs[reg_addr[3:0]] = (reg_wdata & WRITE_MASKS[reg_addr[3:0]])
                | (RESET_VALUES[reg_addr[3:0]] & ~WRITE_MASKS[reg_addr[3:0]]);
        end

        if (reg_read) begin
            next_cur.rvalid = 1'b1;

            next_cur.rdata = (reg_addr < 5'(NUM_REGS)) ? cur.regs[reg_addr[3:0]]
                                                        : 8'h00;
        end

        // a rising power bit restarts that channel's init count
        power_now = {cur.regs[POWER_CONTROL_A][RIGHT_A_POWER],
                     cur.regs[POWER_CONTROL_A][LEFT_A_POWER]};

        // a cleared power bit silences data at once, not one edge later
        live = power_now & cur.ready;

        next_cur.power_prev = power_now;

        for (int ch = 0; ch < 2; ch++) begin
            if (!power_now[ch]) begin
                next_cur.ready[ch] = 1'b0;

                next_cur.init_count[ch] = '0;
            end else if (!cur.power_prev[ch]) begin
                next_cur.ready[ch] = 1'b0;

                next_cur.init_count[ch] = init_length(cur.regs[RATE_AND_FILTER_SELECT],
                                                      cur.regs[CLOCK_OUTPUT_CONFIG]);
            end else if (!cur.ready[ch] && sample_tick) begin
                if (cur.init_count[ch] <= 12'd1) begin
                    next_cur.ready[ch] = 1'b1;

                    next_cur.init_count[ch] = '0;
                end else begin
                    next_cur.init_count[ch] = cur.init_count[ch] - 12'd1;
                end
            end
        end

        // data is held at zero until the channel has finished its init
        if (sample_tick) begin
            next_cur.valid = 1'b1;

            if (cur.regs[SERIAL_FORMAT][MIX_A_ENABLE]) begin
                next_cur.left = live[0] ? mix_sum[SAMPLE_W:1] : '0;

                next_cur.right = live[1] ? mix_sum[SAMPLE_W:1] : '0;
            end else begin
                next_cur.left = live[0] ? adc_left : '0;

                next_cur.right = live[1] ? adc_right : '0;
            end
        end

        // gated clock only; the divider that sets its rate sits outside
        next_cur.clk_out = cur.regs[CLOCK_OUTPUT_CONFIG][CLOCK_OUT_ENABLE]
                           & clock_out_source;

        // pin low: defaults everywhere, registers included
        if (!power_down_pin_n) begin
            next_cur = '0;

            next_cur.regs = RESET_VALUES;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.regs <= RESET_VALUES;
        end else begin
            cur <= next_cur;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    logic [7:0] r_pwr;

    logic [7:0] r_pll;

    logic [7:0] r_route;

    logic [7:0] r_fmt;

    logic [7:0] r_rate;

    logic [7:0] r_clk;

    logic [7:0] r_timer;

    logic [7:0] r_lvl;

    logic [7:0] r_mode;

    assign r_pwr = cur.regs[POWER_CONTROL_A];

    assign r_pll = cur.regs[PLL_AND_ROLE_CONTROL];

    assign r_route = cur.regs[INPUT_ROUTING_A];

    assign r_fmt = cur.regs[SERIAL_FORMAT];

    assign r_rate = cur.regs[RATE_AND_FILTER_SELECT];

    assign r_clk = cur.regs[CLOCK_OUTPUT_CONFIG];

    assign r_timer = cur.regs[LEVEL_TIMER_A];

    assign r_lvl = cur.regs[LEVEL_CONTROL_A];

    assign r_mode = cur.regs[MODE_CONTROL_ONE];

    assign reg_rdata = cur.rdata;

    assign reg_rvalid = cur.rvalid;

    assign out_left = cur.left;

    assign out_right = cur.right;

    assign out_valid = cur.valid;

    assign left_a_ready = cur.ready[0];

    assign right_a_ready = cur.ready[1];

    assign clock_out = cur.clk_out;

    // zeroing power bits only powers down; contents stay
    assign left_a_power = r_pwr[LEFT_A_POWER];

    assign right_a_power = r_pwr[RIGHT_A_POWER];

    assign common_voltage_power = r_pwr[COMMON_VOLTAGE_POWER];

    assign pll_power = r_pll[PLL_POWER];

    assign master_mode = r_pll[MASTER_SELECT];

    assign pll_reference_select = r_pll[PLL_REF_LSB +: 4];

    assign left_a_input = pin_code(r_route[LEFT_A_PIN_SELECT], r_route[LEFT_A_PIN5_SELECT]);

    assign right_a_input = pin_code(r_route[RIGHT_A_PIN_SELECT],
                                    r_route[RIGHT_A_PIN5_SELECT]);

    assign left_a_differential = r_route[LEFT_A_DIFFERENTIAL];

    assign right_a_differential = r_route[RIGHT_A_DIFFERENTIAL];

    assign mic_supply_a_enable = r_route[MIC_SUPPLY_A_ENABLE];

    assign mic_gain_a = cur.regs[MIC_GAIN_A][1:0];

    assign serial_format_select = r_fmt[SERIAL_FORMAT_LSB +: 2];

    assign slot_format_select = r_fmt[SLOT_FORMAT_LSB +: 2];

    assign bitclock_polarity = r_fmt[BITCLOCK_POLARITY];

    assign frameclock_phase = r_fmt[FRAMECLOCK_PHASE];

    assign rate_select = r_rate[RATE_SELECT_LSB +: 4];

    assign bitclock_rate_select = r_rate[BITCLOCK_RATE_LSB +: 2];

    assign clock_out_rate_select = r_clk[CLOCK_OUT_RATE_LSB +: 2];

    // dependent mode reuses the left value; right register itself is untouched
    assign left_a_volume = cur.regs[LEFT_VOLUME_A];

    assign right_a_volume = cur.regs[VOLUME_MODE_A][VOLUME_LINK_A]
                            ? cur.regs[LEFT_VOLUME_A] : cur.regs[RIGHT_VOLUME_A];

    assign recovery_wait_a = {r_timer[RECOVERY_WAIT_HI],
                              r_timer[RECOVERY_WAIT_LO_LSB +: 2]};

    assign zero_cross_timeout_a = r_timer[ZERO_CROSS_LSB +: 2];

    assign first_recovery_speed_a = r_timer[FIRST_RECOVERY_LSB +: 2];

    assign recovery_reference_a = cur.regs[LEVEL_REFERENCE_A];

    assign level_control_a_enable = r_lvl[LEVEL_CONTROL_ENABLE];

    assign limiter_zero_cross_a_disable = r_lvl[LIMITER_ZERO_CROSS_DISABLE];

    assign limiter_step_a = r_lvl[LIMITER_STEP_LSB +: 2];

    assign recovery_step_a = r_lvl[RECOVERY_STEP_LSB +: 2];

    assign limiter_threshold_a = r_lvl[LIMITER_THRESHOLD_LSB +: 2];

    assign level_control_link_all = r_mode[LEVEL_CONTROL_LINK_ALL];

    assign limiter_fast_mode = r_mode[LIMITER_FAST_MODE];

endmodule // adc_group_a_control_registers

/* test/adc_regs_checker_asserts.sv */
module adc_regs_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_down_pin_n,
    // register port
    input wire logic reg_read,
    input wire logic [adc_regs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // sample path
    input wire logic sample_tick,
    input wire logic out_valid,
    input wire logic [adc_regs_pkg::SAMPLE_W-1:0] out_left,
    input wire logic left_a_power,
    input wire logic right_a_power,
    input wire logic left_a_ready,
    // configuration fields
    input wire logic [3:0] pll_reference_select,
    input wire logic [3:0] rate_select,
    input wire logic [7:0] left_a_volume,
    input wire logic [7:0] recovery_reference_a,
    input wire logic clock_out_source,
    input wire logic clock_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import adc_regs_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    AST_READ_ANSWER: assert property (
        power_down_pin_n && reg_read |=> reg_rvalid)
        else $error("read request got no answer");
    AST_ANSWER_CAUSE: assert property (
        reg_rvalid |-> $past(reg_read))
        else $error("read answer without a request");
    AST_UNMAPPED_ZERO: assert property (
        power_down_pin_n && reg_read && reg_addr > 5'h0d |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    AST_PDN_DEFAULTS: assert property (
        !power_down_pin_n |=> left_a_volume == 8'h91 && pll_reference_select == 4'h9
            && rate_select == 4'hf && recovery_reference_a == 8'he1 && !left_a_power)
        else $error("power-down pin did not restore defaults");
    // clock output clears at the same edge as the registers; still only the second low cycle is judged
    AST_PDN_CLOCK_LOW: assert property (
        !power_down_pin_n [*2] |=> !clock_out)
        else $error("clock output not low while disabled");
    AST_CLOCK_GATED: assert property (
        clock_out |-> $past(clock_out_source))
        else $error("clock output high without its source");
    AST_READY_NEEDS_POWER: assert property (
        !left_a_power |=> !left_a_ready)
        else $error("ready kept without power");
    AST_READY_ON_TICK: assert property (
        $rose(left_a_ready) |-> $past(sample_tick))
        else $error("ready rose away from a sample tick");
    AST_SAMPLE_ANSWER: assert property (
        power_down_pin_n && sample_tick |=> out_valid)
        else $error("sample tick gave no output");
    AST_QUIET_WHEN_OFF: assert property (
        sample_tick && !left_a_power && !right_a_power |=> out_left == '0)
        else $error("data delivered from a powered-down channel");
endmodule // adc_regs_checker

bind adc_group_a_control_registers adc_regs_checker u_checker (
    .mclk, .rst_n, .power_down_pin_n, .reg_read, .reg_addr, .reg_rdata, .reg_rvalid,
    .sample_tick, .out_valid, .out_left, .left_a_power, .right_a_power, .left_a_ready,
    .pll_reference_select, .rate_select, .left_a_volume, .recovery_reference_a,
    .clock_out_source, .clock_out);

/* test/host_model.sv */
module host_model (
    // clock
    input wire logic mclk,
    // register requests
    output logic reg_write,
    output logic reg_read,
    output logic [adc_regs_pkg::ADDR_W-1:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import adc_regs_pkg::*;
    initial {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    ////////////////////////////////////////////////////////////////////////////
    // an idle edge before each request, so no strobe is redriven in one time step
    task automatic req(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        #2;
        if (wr && a == 5'h1f) return;
        if (wr && a == 5'h00 && d[1:0] != 2'b00) d[2] = 1'b1;
        {reg_write, reg_read, reg_addr, reg_wdata} = {wr, !wr, a, d};
        @(posedge mclk);
        #2;
        // released strobes drop low; address and data show the inverse, never the stale request
        {reg_write, reg_read, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    endtask
endmodule // host_model

/* test/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_regs_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic power_down_pin_n = 1'b1;
    logic sample_tick = 1'b0;
    logic clock_out_source = 1'b0;
    logic [SAMPLE_W-1:0] adc_left = '0;
    logic [SAMPLE_W-1:0] adc_right = '0;
    logic reg_write, reg_read, reg_rvalid, out_valid, clock_out, pll_power, master_mode;
    logic left_a_power, right_a_power, left_a_ready, right_a_ready, mic_supply_a_enable;
    logic left_a_differential, right_a_differential, smp_on, lr, rr, mixf;
    logic [ADDR_W-1:0] reg_addr;
    logic [1:0] left_a_input, right_a_input;
    logic [3:0] pll_reference_select, rate_select;
    logic [7:0] reg_wdata, reg_rdata, left_a_volume, right_a_volume;
    logic [SAMPLE_W-1:0] out_left, out_right;
    logic [7:0] mdl [NUM_REGS];
    logic [7:0] rq [$];
    logic [31:0] sq [$];
    wire logic [37:0] fld;
    int n_fail = 0;
    int check_count = 0;
    always #10 mclk = ~mclk;
    host_model u_host (.mclk, .reg_write, .reg_read, .reg_addr, .reg_wdata);
    adc_group_a_control_registers u_dut (
        .mclk, .rst_n, .power_down_pin_n, .reg_write, .reg_read, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .sample_tick, .adc_left, .adc_right, .out_left, .out_right,
        .out_valid, .left_a_power, .right_a_power, .common_voltage_power(fld[37]),
        .left_a_ready, .right_a_ready, .mic_supply_a_enable, .left_a_input, .right_a_input,
        .left_a_differential, .right_a_differential, .mic_gain_a(fld[1:0]), .pll_power,
        .master_mode, .pll_reference_select, .rate_select, .bitclock_rate_select(fld[3:2]),
        .serial_format_select(fld[5:4]), .slot_format_select(fld[7:6]),
        .bitclock_polarity(fld[8]), .frameclock_phase(fld[9]),
        .clock_out_rate_select(fld[11:10]), .clock_out_source, .clock_out, .left_a_volume,
        .right_a_volume, .recovery_wait_a(fld[14:12]), .zero_cross_timeout_a(fld[16:15]),
        .first_recovery_speed_a(fld[18:17]), .recovery_reference_a(fld[26:19]),
        .level_control_a_enable(fld[27]), .limiter_zero_cross_a_disable(fld[28]),
        .limiter_step_a(fld[30:29]), .recovery_step_a(fld[32:31]),
        .limiter_threshold_a(fld[34:33]), .level_control_link_all(fld[35]),
        .limiter_fast_mode(fld[36]));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input logic [4:0] a, input logic [7:0] d);
        if (a < 5'd14) mdl[a] = (d & WRITE_MASKS[a]) | (RESET_VALUES[a] & ~WRITE_MASKS[a]);
        u_host.req(1'b1, a, d);
    endtask
    task automatic r(input logic [4:0] a);
        rq.push_back(a < 5'd14 ? mdl[a] : 8'h00);
        u_host.req(1'b0, a, 8'h00);
    endtask
    task automatic rd_all;
        for (int a = 0; a < 16; a++) r(5'(a));
    endtask
    task automatic init_run(input logic [7:0] r5, input logic [7:0] r6, input int n);
        int cnt = 0;
        w(5'h05, r5);
        w(5'h06, r6);
        w(5'h00, 8'h07);
        @(posedge mclk);
        for (int i = 0; i < 8000 && left_a_ready !== 1'b1; i++) begin
            @(posedge mclk);
            if (sample_tick) cnt++;
            #1;
        end
        chk("init_count", 32'(n), 32'(cnt));
        chk("ready", 32'h3, {30'h0, left_a_ready, right_a_ready});
    endtask
    // one spare edge lets a power or mix change settle before samples are judged
    task automatic smp;
        @(posedge mclk);
        #2;
        sq.delete();
        smp_on = 1'b1;
        repeat (12) @(posedge mclk);
        #2 smp_on = 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        #2;
        sample_tick = ~sample_tick;
        adc_left = 16'($urandom);
        adc_right = 16'($urandom);
        clock_out_source = 1'($urandom);
    end
    always @(posedge mclk) begin
        logic signed [16:0] s;
        if (reg_rvalid === 1'b1 && rq.size() > 0)
            chk("reg_rdata", 32'(rq.pop_front()), 32'(reg_rdata));
        if (out_valid === 1'b1 && sq.size() > 0)
            chk("samples", sq.pop_front(), {out_left, out_right});
        if (sample_tick === 1'b1 && smp_on) begin
            s = $signed(adc_left) + $signed(adc_right);
            sq.push_back(mixf ? {2{s[16:1]}} : {lr ? adc_left : 16'h0, rr ? adc_right : 16'h0});
        end
    end
    initial begin
        #(20 * 30000);
        n_fail++;
        $display("wrong value watchdog expected finish seen timeout");
        end_sim();
    end
    initial begin
        logic [1:0] e;
        logic [37:0] fx;
        void'($urandom(40));
        {smp_on, lr, rr, mixf} = 4'h0;
        for (int a = 0; a < 14; a++) mdl[a] = RESET_VALUES[a];
        repeat (3) @(posedge mclk);
        #2 rst_n = 1'b1;
        rd_all();
        r(5'h1f);
        for (int a = 1; a < 14; a++) w(5'(a), 8'($urandom));
        w(5'h0e, 8'hff);
        rd_all();
        chk("pll", {26'h0, mdl[1][5:0]},
            {26'h0, pll_reference_select, master_mode, pll_power});
        chk("rate", 32'(mdl[5][3:0]), 32'(rate_select));
        fx = {mdl[0][2], mdl[13][1:0], mdl[12][1:0], mdl[12][3:2], mdl[12][5:4], mdl[12][6],
              mdl[12][7], mdl[11], mdl[10][6:5], mdl[10][3:2], mdl[10][4], mdl[10][1:0],
              mdl[6][1:0], mdl[4][3:2], mdl[4][7:6], mdl[4][1:0], mdl[5][5:4], mdl[3][1:0]};
        chk("fields", fx[31:0], fld[31:0]);
        chk("fields_hi", 32'(fx[37:32]), 32'(fld[37:32]));
        for (int i = 0; i < 4; i++) begin
            w(5'h02, {1'b0, i[1], i[1], i[0], i[0], i[0], i[0], i[0]});
            e = i[1] ? 2'd2 : {1'b0, i[0]};
            chk("route", {25'h0, {3{i[0]}}, e, e}, {25'h0, mic_supply_a_enable, left_a_differential,
                right_a_differential, left_a_input, right_a_input});
        end
        w(5'h07, 8'h01);
        w(5'h08, 8'h40);
        w(5'h09, 8'h22);
        chk("vol_link", 32'h4040, {16'h0, left_a_volume, right_a_volume});
        w(5'h07, 8'h00);
        chk("vol_split", 32'h4022, {16'h0, left_a_volume, right_a_volume});
        w(5'h00, 8'h00);
        rd_all();
        #2 power_down_pin_n = 1'b0;
        repeat (2) @(posedge mclk);
        #2 power_down_pin_n = 1'b1;
        for (int a = 0; a < 14; a++) mdl[a] = RESET_VALUES[a];
        rd_all();
        init_run(8'hdf, 8'h80, 1552);
        {lr, rr} = 2'b11;
        smp();
        w(5'h04, 8'h33);
        mixf = 1'b1;
        smp();
        w(5'h04, 8'h23);
        w(5'h00, 8'h05);
        {mixf, rr} = 2'b00;
        smp();
        w(5'h00, 8'h04);
        init_run(8'h1f, 8'h80, 3088);
        end_sim();
    end
endmodule // tb_top
